/* File: design/suc_pkg.sv */
// Package for the serial transceiver: register map, fields, prescales and carrier types.
// How it works
// - Mode bit set gives synchronous half duplex, clear gives asynchronous full duplex.
// - Synchronous: clock source set makes host driving clock, clear takes external clock.
// - Nine-bit transmit select sends ninth bit from transmit ninth-bit field.
// - Transmit enable gates transmitter; in synchronous mode receive enables take priority.
// - Asynchronous send-break sends 12-bit break next, hardware clears bit when done.
// - Shift-register-empty reads 1 when transmit shifter is empty, resets to 1.
// - Port enable connects pins; clear holds transmitter, receiver, baud timer and receive flags in reset.
// - Nine-bit receive stores ninth bit in received ninth-bit field, no parity check.
// - Synchronous host single-receive starts one reception, hardware clears it after.
// - Continuous-receive gates asynchronous receiver; synchronous keeps receiving, overrides single.
// - Address detect in nine-bit asynchronous mode accepts only characters with ninth bit 1.
// - Framing error sets on bad stop; clears after read and next valid character.
// - Overrun error sets on overrun, clears when continuous-receive is cleared or the port is disabled.
// - Auto-baud overflow sets on generator rollover during measurement, software clears it.
// - Receiver-idle reads 1 with no reception active, resets to 1.
// - Receive polarity set treats receive or data line as inverted.
// - Polarity bit sets transmit idle level (async) or clock idle level (sync).
// - Sixteen-bit select uses high and low divisor, else low byte only.
// - Wake-up enable flags a falling receive edge, clears itself on next rising edge.
// - Auto-baud measures the next 55h sync character, hardware clears enable when done.
// - Divisor sets free-running timer period; high-speed bit ignored in synchronous mode.
// - Any divisor write resets the baud timer immediately.
// - Bit rate is clock over prescale 64, 16 or 4 times divisor plus one.
// - Each asynchronously received bit is sampled three times and decided by majority; synchronous bits are sampled once.
package suc_pkg;
	// Byte offsets on the register bus
	localparam logic [7:0] OFS_TXCTL = 8'h00;
	localparam logic [7:0] OFS_RCCTL = 8'h04;
	localparam logic [7:0] OFS_BDCTL = 8'h08;
	localparam logic [7:0] OFS_DIVLO = 8'h0C;
	localparam logic [7:0] OFS_DIVHI = 8'h10;
	localparam logic [7:0] OFS_TXDAT = 8'h14;
	localparam logic [7:0] OFS_RXDAT = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	// Field positions
	localparam int TX_CLOCK_SOURCE_SELECT = 7, TX_NINE = 6, TX_EN = 5, TX_SYNC = 4, TX_BREAK = 3, TX_HIGH = 2, TX_EMPTY = 1, TX_D9 = 0;
	localparam int RC_SERIAL_PORT_ENABLE = 7, RC_NINE = 6, RC_SINGLE_RECEIVE_ENABLE = 5, RC_CONTINUOUS_RECEIVE_ENABLE = 4, RC_ADDRESS_DETECT_ENABLE = 3, RC_FRAMING_ERROR_FLAG = 2, RC_OVERRUN_ERROR_FLAG = 1, RC_D9 = 0;
	localparam int BC_OVF = 7, BC_IDLE = 6, BC_RXP = 5, BC_TXP = 4, BC_B16 = 3, BC_WUE = 1, BC_ABD = 0;
	localparam int ST_RXFULL = 0, ST_TXFULL = 1, ST_WAKE = 2;
	// Writable bits and reset values
	localparam logic [7:0] TXCTL_WMASK = 8'hFD;
	localparam logic [7:0] RCCTL_WMASK = 8'hF8;
	localparam logic [7:0] BDCTL_WMASK = 8'h3B;
	localparam logic [7:0] CTL_RST = 8'h00;
	// Prescales and frame figures
	localparam logic [6:0] PRE_SLOW = 7'h40;
	localparam logic [6:0] PRE_FAST = 7'h10;
	localparam logic [6:0] PRE_SYNC = 7'h04;
	localparam logic [3:0] LEN_EIGHT = 4'h8;
	localparam logic [3:0] LEN_NINE = 4'h9;
	localparam logic [3:0] LEN_BREAK = 4'hC;
	localparam logic [5:0] SYNC_SMP_PH = 6'h01;
	localparam logic [5:0] SYNC_ACT_PH = 6'h02;
	localparam logic [2:0] ABD_RISES = 3'h5;
	// Bus request carrier
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} suc_wb_req_t;
	// Pin drive carrier, enables low while driving
	typedef struct packed {
		logic ckOut;
		logic ckOen;
		logic dtOut;
		logic dtOen;
	} suc_pin_out_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11, TX_STOP = 2'b10} suc_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10} suc_rx_state_t;
endpackage

/* File: design/suc_top.sv */
// Serial transceiver with baud generator, auto-baud, wake-up and a Wishbone register slave.
`timescale 1ns/1ps
module suc_top import suc_pkg::*; #(
	parameter int DIV_W = 16
) (
	input wire logic clock, // 200 MHz clock
	input wire logic resetn, // Asynchronous reset, low
	input wire suc_wb_req_t wbReq, // Wishbone request
	output logic [31:0] wbDatO, // Wishbone read data
	output logic wbAck, // Wishbone acknowledge
	input wire logic ckIn, // Transmit or clock pin level
	input wire logic dtIn, // Receive or data pin level
	output suc_pin_out_t pins, // Pin drive and enables
	output logic rxReady, // Receive data waiting
	output logic txReady, // Transmit holding free
	output logic wakeEvent // Wake-up edge seen
);
	logic [7:0] txCtl, rcCtl, bdCtl, divLo, divHi, txHold, rxData, rdVal;
	logic txFull, rxFull, framing_error_flag, overrun_error_flag, rx9, auto_baud_overflow, wakeFlag, wakeSeen;
	logic [DIV_W-1:0] baseCnt, divisor, abdCnt;
	logic [8:0] abdPre, abdPreLast;
	logic [2:0] abdRise;
	logic abdRun, abdDone, auto_baud_enable, abdWrap;
	logic ckS1, ckS2, ckS3, dtS1, dtS2, dtS3;
	logic dtLine, dtPrev, ckAct, ckActPrev, ckLead, ckTrail;
	logic [6:0] prescale;
	logic [5:0] lastPh, midPh, txPh, rxPh;
	logic baseTick, divWrite, req, wrLow, rdReq;
	logic serial_port_enable, syncMode, host, nineTx, nineRx, txp, rxp;
	suc_tx_state_t txSt;
	suc_rx_state_t rxSt;
	logic [11:0] txShift;
	logic [3:0] txCnt, txLen, rxCnt, rxLen;
	logic txBreak, syncRx, txBitEnd, txAdv, clrBreak, clrSren, clrWue;
	logic syncSmp, syncDone, rxEnA, rxBitEnd, rxSmp, rxMaj, asyncDone, charDone, accept;
	logic [2:0] vote;
	logic [8:0] rxShift;
	logic txEmpty, rxIdle, lineBit;

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Control decode
	assign serial_port_enable = rcCtl[RC_SERIAL_PORT_ENABLE];
	assign syncMode = txCtl[TX_SYNC];
	assign host = txCtl[TX_CLOCK_SOURCE_SELECT];
	assign nineTx = txCtl[TX_NINE];
	assign nineRx = rcCtl[RC_NINE];
	assign txp = bdCtl[BC_TXP];
	assign rxp = bdCtl[BC_RXP];
	assign auto_baud_enable = bdCtl[BC_ABD] & ~syncMode & serial_port_enable;

	// Bus decode: one answer cycle for every request, mapped or not
	assign req = wbReq.cyc & wbReq.stb & ~wbAck;
	assign wrLow = req & wbReq.we & wbReq.sel[0];
	assign rdReq = req & ~wbReq.we;
	assign divWrite = (wrLow && (wbReq.adr == OFS_DIVLO || wbReq.adr == OFS_DIVHI)) || abdDone;

	// Acknowledge and registered read data
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wbAck <= 1'b0;
			wbDatO <= 32'h0000_0000;
		end else begin
			wbAck <= req;
			if (rdReq) wbDatO <= {24'h00_0000, rdVal};
		end
	end

	// Read multiplexer, status bits merged over stored control bits
	always_comb begin
		rdVal = 8'h00;
		if (wbReq.adr == OFS_TXCTL) begin
			rdVal = txCtl;
			rdVal[TX_EMPTY] = txEmpty;
		end else if (wbReq.adr == OFS_RCCTL) begin
			rdVal = rcCtl;
			rdVal[RC_FRAMING_ERROR_FLAG] = framing_error_flag;
			rdVal[RC_OVERRUN_ERROR_FLAG] = overrun_error_flag;
			rdVal[RC_D9] = rx9;
		end else if (wbReq.adr == OFS_BDCTL) begin
			rdVal = bdCtl;
			rdVal[BC_OVF] = auto_baud_overflow;
			rdVal[BC_IDLE] = rxIdle;
		end else if (wbReq.adr == OFS_DIVLO) begin
			rdVal = divLo;
		end else if (wbReq.adr == OFS_DIVHI) begin
			rdVal = divHi;
		end else if (wbReq.adr == OFS_RXDAT) begin
			rdVal = rxData;
		end else if (wbReq.adr == OFS_STAT) begin
			rdVal[ST_RXFULL] = rxFull;
			rdVal[ST_TXFULL] = txFull;
			rdVal[ST_WAKE] = wakeFlag;
		end
	end

	// Control registers; hardware clears come first so a software write wins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txCtl <= CTL_RST;
			rcCtl <= CTL_RST;
			bdCtl <= CTL_RST;
			divLo <= CTL_RST;
			divHi <= CTL_RST;
		end else begin
			if (clrBreak) txCtl[TX_BREAK] <= 1'b0;
			if (clrSren) rcCtl[RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
			if (clrWue) bdCtl[BC_WUE] <= 1'b0;
			if (abdDone) begin
				bdCtl[BC_ABD] <= 1'b0;
				{divHi, divLo} <= 16'(abdCnt - 1'b1);
			end
			if (wrLow) begin
				if (wbReq.adr == OFS_TXCTL) txCtl <= wbReq.dat[7:0] & TXCTL_WMASK;
				else if (wbReq.adr == OFS_RCCTL) rcCtl <= wbReq.dat[7:0] & RCCTL_WMASK;
				else if (wbReq.adr == OFS_BDCTL) bdCtl <= wbReq.dat[7:0] & BDCTL_WMASK;
				else if (wbReq.adr == OFS_DIVLO) divLo <= wbReq.dat[7:0];
				else if (wbReq.adr == OFS_DIVHI) divHi <= wbReq.dat[7:0];
			end
		end
	end

	// Prescale and divisor selection
	always_comb begin
		if (syncMode) prescale = PRE_SYNC;
		else if (txCtl[TX_HIGH] || bdCtl[BC_B16]) prescale = PRE_FAST;
		else prescale = PRE_SLOW;
		if (bdCtl[BC_B16]) divisor = DIV_W'({divHi, divLo});
		else divisor = DIV_W'(divLo);
	end
	assign lastPh = 6'(prescale - 7'h01);
	assign midPh = prescale[6:1];
	assign baseTick = serial_port_enable && (baseCnt == divisor);

	// Free-running baud timer, cleared by any divisor write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) baseCnt <= '0;
		else if (!serial_port_enable || divWrite) baseCnt <= '0;
		else if (baseCnt == divisor) baseCnt <= '0;
		else baseCnt <= baseCnt + 1'b1;
	end

	// Pin synchronisers; the third stage feeds edge detection
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ckS1 <= 1'b0;
			ckS2 <= 1'b0;
			ckS3 <= 1'b0;
			dtS1 <= 1'b1;
			dtS2 <= 1'b1;
			dtS3 <= 1'b1;
		end else begin
			ckS1 <= ckIn;
			ckS2 <= ckS1;
			ckS3 <= ckS2;
			dtS1 <= dtIn;
			dtS2 <= dtS1;
			dtS3 <= dtS2;
		end
	end
	assign dtLine = dtS2 ^ rxp;
	assign dtPrev = dtS3 ^ rxp;
	assign ckAct = ckS2 ^ txp;
	assign ckActPrev = ckS3 ^ txp;
	assign ckLead = ckAct & ~ckActPrev;
	assign ckTrail = ~ckAct & ckActPrev;

	// Transmit and synchronous engine timing
	assign txBitEnd = baseTick && (txPh == lastPh);
	assign txAdv = (syncMode && !host) ? ckTrail : txBitEnd;
	assign txLen = txBreak ? LEN_BREAK : (nineTx ? LEN_NINE : LEN_EIGHT);
	assign syncSmp = syncRx && (txSt == TX_DATA) && (host ? (baseTick && txPh == SYNC_SMP_PH) : ckLead);
	assign syncDone = syncRx && (txSt == TX_DATA) && txAdv && (txCnt == 4'(rxLen - 1'b1));
	assign clrBreak = txBreak && (txSt == TX_STOP) && txBitEnd;
	assign clrSren = syncDone && host && !rcCtl[RC_CONTINUOUS_RECEIVE_ENABLE];
	assign txEmpty = (txSt == TX_IDLE) || syncRx;

	// Transmitter, holding register and half-duplex synchronous sequencer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txSt <= TX_IDLE;
			txPh <= 6'h00;
			txCnt <= 4'h0;
			txShift <= 12'h000;
			txBreak <= 1'b0;
			syncRx <= 1'b0;
			txHold <= 8'h00;
			txFull <= 1'b0;
		end else if (!serial_port_enable) begin
			txSt <= TX_IDLE;
			txPh <= 6'h00;
			txBreak <= 1'b0;
			syncRx <= 1'b0;
			txFull <= 1'b0;
		end else begin
			if (wrLow && wbReq.adr == OFS_TXDAT && !txFull) begin
				txHold <= wbReq.dat[7:0];
				txFull <= 1'b1;
			end
			if (baseTick) txPh <= (txPh == lastPh) ? 6'h00 : txPh + 1'b1;
			case (txSt)
				TX_IDLE: begin
					txCnt <= 4'h0;
					txPh <= 6'h00;
					if (syncMode && ((host && rcCtl[RC_SINGLE_RECEIVE_ENABLE]) || rcCtl[RC_CONTINUOUS_RECEIVE_ENABLE])) begin
						syncRx <= 1'b1;
						txSt <= TX_DATA;
					end else if (txCtl[TX_EN] && txFull) begin
						txFull <= 1'b0;
						txBreak <= txCtl[TX_BREAK] && !syncMode;
						if (txCtl[TX_BREAK] && !syncMode) txShift <= 12'h000;
						else txShift <= {3'b000, txCtl[TX_D9], txHold};
						txSt <= syncMode ? TX_DATA : TX_START;
					end
				end
				TX_START: begin
					if (txBitEnd) txSt <= TX_DATA;
				end
				TX_DATA: begin
					if (txAdv) begin
						txShift <= {1'b0, txShift[11:1]};
						txCnt <= txCnt + 1'b1;
						if (txCnt == 4'((syncRx ? rxLen : txLen) - 1'b1)) begin
							txSt <= syncMode ? TX_IDLE : TX_STOP;
							syncRx <= 1'b0;
						end
					end
				end
				TX_STOP: begin
					if (txBitEnd) begin
						txSt <= TX_IDLE;
						txBreak <= 1'b0;
					end
				end
				default: txSt <= TX_IDLE;
			endcase
		end
	end

	// Pin drivers, enables low while driving
	always_comb begin
		if (txSt == TX_START) lineBit = 1'b0;
		else if (txSt == TX_DATA) lineBit = txShift[0];
		else lineBit = 1'b1;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pins <= '{ckOut: 1'b0, ckOen: 1'b1, dtOut: 1'b0, dtOen: 1'b1};
		end else if (!serial_port_enable) begin
			pins <= '{ckOut: 1'b0, ckOen: 1'b1, dtOut: 1'b0, dtOen: 1'b1};
		end else if (!syncMode) begin
			pins.ckOut <= lineBit ^ txp;
			pins.ckOen <= 1'b0;
			pins.dtOut <= 1'b0;
			pins.dtOen <= 1'b1;
		end else begin
			pins.ckOut <= txp ^ ((txSt == TX_DATA) && (txPh >= SYNC_ACT_PH));
			pins.ckOen <= ~host;
			pins.dtOut <= txShift[0] ^ rxp;
			pins.dtOen <= ~((txSt == TX_DATA) && !syncRx);
		end
	end

	// Asynchronous receiver timing with three-sample majority
	assign rxEnA = serial_port_enable && !syncMode && rcCtl[RC_CONTINUOUS_RECEIVE_ENABLE] && !auto_baud_enable;
	assign rxLen = nineRx ? LEN_NINE : LEN_EIGHT;
	assign rxBitEnd = baseTick && (rxPh == lastPh);
	assign rxSmp = baseTick && (rxPh == 6'(midPh - 1'b1) || rxPh == midPh || rxPh == 6'(midPh + 1'b1));
	assign rxMaj = maj3(vote);
	assign asyncDone = (rxSt == RX_STOP) && rxBitEnd;
	assign rxIdle = syncMode ? !syncRx : (rxSt == RX_IDLE);

	// Receive shifter for both modes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxSt <= RX_IDLE;
			rxPh <= 6'h00;
			rxCnt <= 4'h0;
			vote <= 3'b111;
			rxShift <= 9'h000;
		end else if (syncMode || !rxEnA) begin
			rxSt <= RX_IDLE;
			rxPh <= 6'h00;
			if (syncSmp) rxShift <= {dtLine, rxShift[8:1]};
		end else begin
			if (baseTick) rxPh <= (rxPh == lastPh) ? 6'h00 : rxPh + 1'b1;
			if (rxSmp) vote <= {vote[1:0], dtLine};
			case (rxSt)
				RX_IDLE: begin
					rxPh <= 6'h00;
					rxCnt <= 4'h0;
					if (!dtLine) rxSt <= RX_START;
				end
				RX_START: begin
					if (rxBitEnd) rxSt <= rxMaj ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rxBitEnd) begin
						rxShift <= {rxMaj, rxShift[8:1]};
						rxCnt <= rxCnt + 1'b1;
						if (rxCnt == 4'(rxLen - 1'b1)) rxSt <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rxBitEnd) rxSt <= RX_IDLE;
				end
				default: rxSt <= RX_IDLE;
			endcase
		end
	end

	// Character delivery, error flags; a character completing in the cycle a full buffer is read counts as overrun
	assign charDone = asyncDone || syncDone;
	assign accept = charDone && !(!syncMode && nineRx && rcCtl[RC_ADDRESS_DETECT_ENABLE] && !rxShift[8]);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxData <= 8'h00;
			rx9 <= 1'b0;
			rxFull <= 1'b0;
			framing_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
		end else if (!serial_port_enable) begin
			rxFull <= 1'b0;
			framing_error_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
		end else begin
			if (rdReq && wbReq.adr == OFS_RXDAT) rxFull <= 1'b0;
			if (wrLow && wbReq.adr == OFS_RCCTL && !wbReq.dat[RC_CONTINUOUS_RECEIVE_ENABLE]) overrun_error_flag <= 1'b0;
			if (accept) begin
				if (rxFull || overrun_error_flag) begin
					overrun_error_flag <= 1'b1;
				end else begin
					rxData <= nineRx ? rxShift[7:0] : rxShift[8:1];
					rx9 <= nineRx & rxShift[8];
					framing_error_flag <= !syncMode && !rxMaj;
					rxFull <= 1'b1;
				end
			end
		end
	end

	// Auto-baud: count 8*prescale clocks per unit from first to fifth rising edge
	assign abdPreLast = {prescale[5:0], 3'b000} - 9'h001; // Wraps to 511 for prescale 64
	assign abdWrap = abdRun && (abdPre == abdPreLast) && (abdCnt == '1);
	assign abdDone = abdRun && dtLine && !dtPrev && (abdRise == 3'(ABD_RISES - 1'b1));
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			abdRun <= 1'b0;
			abdRise <= 3'h0;
			abdPre <= 9'h000;
			abdCnt <= '0;
			auto_baud_overflow <= 1'b0;
		end else begin
			if (wrLow && wbReq.adr == OFS_BDCTL && !wbReq.dat[BC_OVF]) auto_baud_overflow <= 1'b0;
			if (abdWrap) auto_baud_overflow <= 1'b1;
			if (!auto_baud_enable || abdDone) begin
				abdRun <= 1'b0;
				abdRise <= 3'h0;
			end else if (dtLine && !dtPrev) begin
				abdRun <= 1'b1;
				abdRise <= abdRise + 1'b1;
				// The edge cycle counts as the first clock of the measurement
				if (!abdRun) begin
					abdPre <= 9'h001;
					abdCnt <= '0;
				end
			end
			if (abdRun && !abdDone) begin
				abdPre <= (abdPre == abdPreLast) ? 9'h000 : abdPre + 1'b1;
				if (abdPre == abdPreLast) abdCnt <= abdCnt + 1'b1;
			end
		end
	end

	// Wake-up edge watch; software clears the flag by writing one, a new edge wins
	assign clrWue = wakeSeen && dtLine && !dtPrev;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wakeFlag <= 1'b0;
			wakeSeen <= 1'b0;
		end else begin
			if (wrLow && wbReq.adr == OFS_STAT && wbReq.dat[ST_WAKE]) wakeFlag <= 1'b0;
			if (!(bdCtl[BC_WUE] && serial_port_enable && !syncMode) || clrWue) begin
				wakeSeen <= 1'b0;
			end else if (!dtLine && dtPrev) begin
				wakeSeen <= 1'b1;
				wakeFlag <= 1'b1;
			end
		end
	end

	// Registered user status outputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxReady <= 1'b0;
			txReady <= 1'b0;
			wakeEvent <= 1'b0;
		end else begin
			rxReady <= rxFull;
			txReady <= serial_port_enable && !txFull;
			wakeEvent <= wakeFlag;
		end
	end
endmodule // suc_top

/* File: verification/suc_serial_peer.sv */
// Serial peer model: sends and captures asynchronous characters on the pins.
`timescale 1ns/1ps
module suc_serial_peer #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clock, // Bench clock
	input wire logic lineIn, // Device transmit pin level
	output logic lineOut // Device receive pin drive
);
	// Line idles high between characters
	initial lineOut = 1'h1;
	// Low start, data LSB first, chosen stop level, then idle
	task automatic send(input logic [8:0] d, input int n, input logic stopBit);
		int i;
		@(posedge clock);
		lineOut <= 1'h0;
		repeat (BIT_CLKS) @(posedge clock);
		for (i = 0; i < n; i++) begin
			lineOut <= d[i];
			repeat (BIT_CLKS) @(posedge clock);
		end
		lineOut <= stopBit;
		repeat (BIT_CLKS) @(posedge clock);
		lineOut <= 1'h1;
		repeat (BIT_CLKS) @(posedge clock);
	endtask
	// Bounded wait for a low line
	task automatic waitLow(output bit seen);
		int k;
		seen = 0;
		for (k = 0; k < 4000 && !seen; k++) begin
			@(posedge clock);
			seen = (lineIn === 1'h0);
		end
	endtask
	// Mid-bit capture, start bit in bit 0
	task automatic recv(input int n, output logic [10:0] f);
		bit seen;
		int i;
		f = 'x;
		waitLow(seen);
		if (seen) begin
			repeat (BIT_CLKS / 2) @(posedge clock);
			for (i = 0; i < n; i++) begin
				f[i] = lineIn;
				repeat (BIT_CLKS) @(posedge clock);
			end
		end
	endtask
	// Length of the next low stretch in clocks
	task automatic lowRun(output int len);
		bit seen;
		len = 0;
		waitLow(seen);
		while (seen && lineIn === 1'h0 && len < 4000) begin
			@(posedge clock);
			len++;
		end
	endtask
	// Low pulse used as a wake-up edge pair
	task automatic pulseLow(input int n);
		@(posedge clock);
		lineOut <= 1'h0;
		repeat (n) @(posedge clock);
		lineOut <= 1'h1;
		repeat (BIT_CLKS) @(posedge clock);
	endtask
endmodule // suc_serial_peer

/* File: verification/suc_top_asserts.sv */
// Checker of bus handshake, port enable and wake flag at the transceiver ports.
`timescale 1ns/1ps
module suc_top_asserts import suc_pkg::*; #(
	parameter int DIV_W = 16
) (
	input wire logic clock, // Clock
	input wire logic resetn, // Reset, low
	input wire suc_wb_req_t wbReq, // Bus request
	input wire logic [31:0] wbDatO, // Read data
	input wire logic wbAck, // Acknowledge
	input wire suc_pin_out_t pins, // Pin drive
	input wire logic rxReady, // Receive waiting
	input wire logic txReady, // Transmit free
	input wire logic wakeEvent // Wake flag
);
	logic taken;
	logic statWr;
	logic spenSeen;
	logic spenOld;
	logic spenOlder;
	logic statRecent;
	// Requests the slave takes
	assign taken = wbReq.cyc && wbReq.stb && !wbAck;
	assign statWr = taken && wbReq.we && wbReq.adr == OFS_STAT;
	// Shadow of the port enable and of recent status writes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			spenSeen <= 1'h0;
			spenOld <= 1'h0;
			spenOlder <= 1'h0;
			statRecent <= 1'h0;
		end else begin
			if (taken && wbReq.we && wbReq.sel[0] && wbReq.adr == OFS_RCCTL) begin
				spenSeen <= wbReq.dat[RC_SERIAL_PORT_ENABLE];
			end
			spenOld <= spenSeen;
			spenOlder <= spenOld;
			statRecent <= statWr;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence reqTaken;
		wbReq.cyc && wbReq.stb && !wbAck;
	endsequence
	sequence ackPulse;
		wbAck ##1 !wbAck;
	endsequence
	AST_ACK_ONE_CYCLE: assert property (reqTaken |=> ackPulse)
		else $error("ack not a one-cycle pulse after request");
	AST_ACK_CAUSE: assert property (wbAck |-> $past(wbReq.stb) && $past(wbReq.cyc) && !$past(wbAck))
		else $error("ack without a pending request");
	AST_RD_HIGH_ZERO: assert property (wbAck |-> wbDatO[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	// Ready flags trail the cleared enable by one (transmit) or two (receive) registered stages
	AST_PORT_OFF_PINS: assert property (!spenSeen && !spenOld && !spenOlder |-> pins.ckOen && pins.dtOen)
		else $error("pins driven while port disabled");
	AST_PORT_OFF_FLAGS: assert property (!spenSeen && !spenOld && !spenOlder |-> !txReady && !rxReady)
		else $error("ready flags while port disabled");
	AST_TXREADY_PORT: assert property ($rose(txReady) |-> spenSeen && spenOld)
		else $error("transmit ready rose with port off");
	AST_WAKE_HOLDS: assert property (wakeEvent && spenSeen && !statWr && !statRecent |=> wakeEvent)
		else $error("wake flag dropped without clear");
	AST_RX_READ_CLEARS: assert property (taken && !wbReq.we && wbReq.adr == OFS_RXDAT |-> ##[1:3] !rxReady)
		else $error("receive ready stayed after read");
endmodule // suc_top_asserts
bind suc_top suc_top_asserts #(.DIV_W(DIV_W)) suc_top_asserts_i (.clock(clock), .resetn(resetn),
	.wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .pins(pins), .rxReady(rxReady),
	.txReady(txReady), .wakeEvent(wakeEvent));

/* File: verification/suc_top_tb.sv */
// Testbench of the serial transceiver: registers, frames, break, errors, wake and sync receive.
`timescale 1ns/1ps
module suc_top_tb import suc_pkg::*;;
	localparam int BIT = 32; // Prescale 16 times divisor one plus one
	logic clock;
	logic resetn;
	suc_wb_req_t wbReq;
	logic [31:0] wbDatO;
	logic wbAck;
	suc_pin_out_t pins;
	logic rxReady, txReady, wakeEvent, txWire, dtWire, peerLine;
	logic [7:0] q;
	logic [10:0] f;
	int nErrors = 0;
	int nCompared = 0;
	int len;
	// Released pins float high
	assign txWire = pins.ckOen ? 1'h1 : pins.ckOut;
	assign dtWire = peerLine & (pins.dtOen | pins.dtOut);
	suc_top #(.DIV_W(16)) suc_top_i (.clock(clock), .resetn(resetn), .wbReq(wbReq), .wbDatO(wbDatO),
		.wbAck(wbAck), .ckIn(txWire), .dtIn(dtWire), .pins(pins), .rxReady(rxReady), .txReady(txReady),
		.wakeEvent(wakeEvent));
	suc_serial_peer #(.BIT_CLKS(BIT)) suc_serial_peer_i (.clock(clock), .lineIn(txWire), .lineOut(peerLine));
	// Clock of 5 ns
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task automatic printVerdict();
		$display("compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nErrors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One classic bus cycle held until ack is sampled
	task automatic acc(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int k;
		@(posedge clock);
		wbReq <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, d}};
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wbAck !== 1'h1 && k < 20);
		q = wbDatO[7:0];
		wbReq <= '0;
		if (wbAck !== 1'h1) begin
			nErrors++;
			printVerdict();
		end
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		acc(1'h1, adr, d);
	endtask
	task automatic rd(input logic [7:0] adr);
		acc(1'h0, adr, 8'h00);
	endtask
	initial begin
		resetn = 1'h0;
		wbReq = '0;
		repeat (3) @(posedge clock);
		resetn <= 1'h1;
		// Reset values, unmapped address, released pin
		rd(OFS_TXCTL);
		check("txctl", q, 8'h02);
		rd(OFS_BDCTL);
		check("bdctl", q, 8'h40);
		rd(8'h20);
		check("unmapped", q, 8'h00);
		check("ckoen", pins.ckOen, 1'h1);
		// High divisor byte ignored in 8-bit mode
		wr(OFS_DIVLO, 8'h01);
		wr(OFS_DIVHI, 8'h5A);
		wr(OFS_RCCTL, 8'h80);
		wr(OFS_TXCTL, 8'h65);
		repeat (4) @(posedge clock);
		check("txready", txReady, 1'h1);
		// Nine-bit frame, shifter busy meanwhile
		fork
			suc_serial_peer_i.recv(11, f);
			begin
				wr(OFS_TXDAT, 8'hA5);
				repeat (8) @(posedge clock);
				rd(OFS_TXCTL);
				check("busy", q[TX_EMPTY], 1'h0);
			end
		join
		check("frame", f, {1'h1, 9'h1A5, 1'h0});
		repeat (2 * BIT) @(posedge clock);
		rd(OFS_TXCTL);
		check("txctl", q, 8'h67);
		// Break of start plus twelve low bits
		wr(OFS_TXCTL, 8'h2C);
		fork
			suc_serial_peer_i.lowRun(len);
			wr(OFS_TXDAT, 8'h00);
		join
		check("break", len >= 13 * BIT - 6 && len <= 13 * BIT + 6, 1'h1);
		repeat (2 * BIT) @(posedge clock);
		rd(OFS_TXCTL);
		check("send_break", q, 8'h26);
		// Idle level follows polarity
		wr(OFS_BDCTL, 8'h10);
		repeat (4) @(posedge clock);
		check("idle", txWire, 1'h0);
		wr(OFS_BDCTL, 8'h00);
		// Nine-bit receive, receiver busy mid-frame
		wr(OFS_RCCTL, 8'hD0);
		fork
			suc_serial_peer_i.send(9'h13C, 9, 1'h1);
			begin
				repeat (3 * BIT) @(posedge clock);
				rd(OFS_BDCTL);
				check("receiver_idle", q[BC_IDLE], 1'h0);
			end
		join
		check("rxready", rxReady, 1'h1);
		rd(OFS_RXDAT);
		check("rxdata", q, 8'h3C);
		rd(OFS_RCCTL);
		check("received_ninth_bit", q, 8'hD1);
		// Framing error, cleared by read and good character
		suc_serial_peer_i.send(9'h055, 9, 1'h0);
		rd(OFS_RCCTL);
		check("framing_error_flag", q, 8'hD4);
		rd(OFS_RXDAT);
		suc_serial_peer_i.send(9'h101, 9, 1'h1);
		rd(OFS_RCCTL);
		check("framing_error_flag", q, 8'hD1);
		rd(OFS_RXDAT);
		// Overrun kept until receiver disabled
		suc_serial_peer_i.send(9'h1AA, 9, 1'h1);
		suc_serial_peer_i.send(9'h1BB, 9, 1'h1);
		rd(OFS_RCCTL);
		check("overrun_error_flag", q[RC_OVERRUN_ERROR_FLAG], 1'h1);
		rd(OFS_RXDAT);
		check("kept", q, 8'hAA);
		wr(OFS_RCCTL, 8'hC0);
		rd(OFS_RCCTL);
		check("overrun_error_flag", q[RC_OVERRUN_ERROR_FLAG], 1'h0);
		// Address detect drops ninth bit zero
		wr(OFS_RCCTL, 8'hD8);
		suc_serial_peer_i.send(9'h011, 9, 1'h1);
		check("skip", rxReady, 1'h0);
		suc_serial_peer_i.send(9'h122, 9, 1'h1);
		rd(OFS_RXDAT);
		check("addr", q, 8'h22);
		// Auto-baud on a 55h sync field rewrites the divisor pair
		wr(OFS_DIVLO, 8'h07);
		wr(OFS_BDCTL, 8'h01);
		suc_serial_peer_i.send(9'h055, 8, 1'h1);
		rd(OFS_DIVLO);
		check("abdlo", q, 8'h01);
		rd(OFS_DIVHI);
		check("abdhi", q, 8'h00);
		rd(OFS_BDCTL);
		check("auto_baud_enable", q, 8'h40);
		// Wake on falling edge, enable cleared on rising edge
		wr(OFS_RCCTL, 8'h80);
		wr(OFS_BDCTL, 8'h02);
		suc_serial_peer_i.pulseLow(BIT);
		check("wake", wakeEvent, 1'h1);
		rd(OFS_BDCTL);
		check("wue", q[BC_WUE], 1'h0);
		wr(OFS_STAT, 8'h04);
		repeat (4) @(posedge clock);
		check("wake", wakeEvent, 1'h0);
		// Port off releases pins
		wr(OFS_RCCTL, 8'h00);
		repeat (4) @(posedge clock);
		check("off", {txReady, pins.ckOen, pins.dtOen}, 3'h3);
		// Sync host single receive
		wr(OFS_TXCTL, 8'h90);
		wr(OFS_RCCTL, 8'hA0);
		repeat (8) @(posedge clock);
		check("host", pins.ckOen, 1'h0);
		repeat (150) @(posedge clock);
		rd(OFS_RCCTL);
		check("single_receive_enable", q[RC_SINGLE_RECEIVE_ENABLE], 1'h0);
		rd(OFS_RXDAT);
		check("sync", q, 8'hFF);
		printVerdict();
	end
endmodule // suc_top_tb
